/* ist_timing.sv */
// Purpose: per-instruction state count for the processor core timing model
// Assumes: instValid and inputs come from logic on clk; no synchroniser needed
// Notes:   result appears one clock after the request and holds until the next one
//
// Contract
// RULE1: fetch cost per target: 2,6,3,4,2
// RULE2: external 3-state: word 6+2m, narrow 3+m
// RULE3: 8-bit data: module 3/6, external 2/4
// RULE4: long add immediate: three fetches only
// RULE5: 16-bit immediates two fetches; registers one (the code gives the long AND register form two fetches)
// RULE6: 8-bit displacement branch: two fetches always
// RULE7: bit-and carry: register 1, memory 2+1byte
// RULE8: total equals sum of count times cost
// RULE9: internal cycle one state; unsigned total
`timescale 1ns/10ps
module ist_timing
   import ist_pkg::*;
#(
   parameter int WAIT_WIDTH = WAIT_W
)
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  instValid,
   input  wire ist_class_e            instClass,
   input  wire ist_target_e           target,
   input  wire logic [WAIT_W-1:0]     waitStates,
   input  wire logic                  branchTaken,
   output logic                       countValid,
   output logic [TOTAL_W-1:0]         stateCount,
   output logic [CNT_W-1:0]           fetchCycles,
   output logic [CNT_W-1:0]           branchCycles,
   output logic [CNT_W-1:0]           stackCycles,
   output logic [CNT_W-1:0]           byteCycles,
   output logic [CNT_W-1:0]           wordCycles,
   output logic [CNT_W-1:0]           internalCycles,
   output logic [ACC_W-1:0]           instTotal,
   output logic [ACC_W-1:0]           stateTotal,
   output logic                       unknownClass
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // cycle-count decode, packed as {I,J,K,L,M,N}
   function automatic logic [6*CNT_W-1:0] cycle_counts(input ist_class_e cls);
      logic [6*CNT_W-1:0] c;
      c = {6{CNT_NONE}};
      case (cls)
         CLS_ADD_L_IMM: begin
            c = {CNT_THREE, {5{CNT_NONE}}}; // RULE4
         end
         CLS_AND_L_IMM: begin
            c = {CNT_THREE, {5{CNT_NONE}}};
         end
         CLS_ADD_W_IMM: begin
            c = {CNT_TWO, {5{CNT_NONE}}}; // RULE5
         end
         CLS_AND_W_IMM: begin
            c = {CNT_TWO, {5{CNT_NONE}}}; // RULE5
         end
         CLS_AND_L_REG: begin
            c = {CNT_TWO, {5{CNT_NONE}}}; // RULE5
         end
         // one fetch only; each class stands alone so a single entry can be retimed safely
         CLS_ADD_B_IMM: begin
            c = {CNT_ONE, {5{CNT_NONE}}};
         end
         CLS_ADD_B_REG: begin
            c = {CNT_ONE, {5{CNT_NONE}}}; // RULE5
         end
         CLS_ADD_W_REG: begin
            c = {CNT_ONE, {5{CNT_NONE}}}; // RULE5
         end
         CLS_ADD_L_REG: begin
            c = {CNT_ONE, {5{CNT_NONE}}}; // RULE5
         end
         CLS_ADD_PTR: begin
            c = {CNT_ONE, {5{CNT_NONE}}};
         end
         CLS_ADDX_IMM: begin
            c = {CNT_ONE, {5{CNT_NONE}}};
         end
         CLS_ADDX_REG: begin
            c = {CNT_ONE, {5{CNT_NONE}}};
         end
         CLS_AND_B_IMM: begin
            c = {CNT_ONE, {5{CNT_NONE}}};
         end
         CLS_AND_B_REG: begin
            c = {CNT_ONE, {5{CNT_NONE}}}; // RULE5
         end
         CLS_AND_W_REG: begin
            c = {CNT_ONE, {5{CNT_NONE}}}; // RULE5
         end
         CLS_AND_CCR: begin
            c = {CNT_ONE, {5{CNT_NONE}}};
         end
         CLS_BITAND_REG: begin
            c = {CNT_ONE, {5{CNT_NONE}}}; // RULE7
         end
         CLS_BITAND_IND, CLS_BITAND_ABS: begin
            c = {CNT_TWO, CNT_NONE, CNT_NONE, CNT_ONE, CNT_NONE, CNT_NONE}; // RULE7
         end
         CLS_BRANCH_D8: begin
            c = {CNT_TWO, {5{CNT_NONE}}}; // RULE6
         end
         default: begin
            c = {6{CNT_NONE}};
         end
      endcase
      return c;
   endfunction

   function automatic logic known_class(input ist_class_e cls);
      return (cls <= CLS_BRANCH_D8);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////
   // per-cycle costs for the selected target
   logic [COST_W-1:0] costFetch;
   logic [COST_W-1:0] costBranch;
   logic [COST_W-1:0] costStack;
   logic [COST_W-1:0] costByte;
   logic [COST_W-1:0] costWord;
   logic [COST_W-1:0] costInternal;

   ist_cycle_cost u_cost (
      .target       (target),
      .waitStates   (waitStates),
      .costFetch    (costFetch),
      .costBranch   (costBranch),
      .costStack    (costStack),
      .costByte     (costByte),
      .costWord     (costWord),
      .costInternal (costInternal)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // combine counts and costs
   // taken or not, the short branch costs the same; branchTaken is deliberately unused
   wire [6*CNT_W-1:0] counts = cycle_counts(instClass); // RULE6
   wire               classOk = known_class(instClass);

   wire [CNT_W-1:0] cntI = counts[11:10];
   wire [CNT_W-1:0] cntJ = counts[9:8];
   wire [CNT_W-1:0] cntK = counts[7:6];
   wire [CNT_W-1:0] cntL = counts[5:4];
   wire [CNT_W-1:0] cntM = counts[3:2];
   wire [CNT_W-1:0] cntN = counts[1:0];

   wire [COST_W-1:0] costs [6];
   wire [CNT_W-1:0]  cnts  [6];
   wire [TOTAL_W-1:0] partial [6];

   assign costs[0] = costFetch;
   assign costs[1] = costBranch;
   assign costs[2] = costStack;
   assign costs[3] = costByte;
   assign costs[4] = costWord;
   assign costs[5] = costInternal; // RULE9
   assign cnts[0]  = cntI;
   assign cnts[1]  = cntJ;
   assign cnts[2]  = cntK;
   assign cnts[3]  = cntL;
   assign cnts[4]  = cntM;
   assign cnts[5]  = cntN;

   for (genvar g = 0; g < 6; g++) begin : g_prod
      assign partial[g] = TOTAL_W'(cnts[g]) * TOTAL_W'(costs[g]); // RULE8
   end

   // widths keep every partial far below overflow, so a plain sum is exact
   wire [TOTAL_W-1:0] sumNxt = partial[0] + partial[1] + partial[2]
                             + partial[3] + partial[4] + partial[5]; // RULE8

   ////////////////////////////////////////////////////////////////////////////////////////
   // registered results
   logic [TOTAL_W-1:0] stateCount_r;
   logic [6*CNT_W-1:0] counts_r;
   logic               countValid_r;
   logic               unknown_r;
   logic [ACC_W-1:0]   instTotal_r;
   logic [ACC_W-1:0]   stateTotal_r;

   wire [ACC_W-1:0] instTotal_nxt  = instTotal_r + ACC_W'(1);
   wire [ACC_W-1:0] stateTotal_nxt = stateTotal_r + ACC_W'(sumNxt);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         countValid_r <= 1'b0;
      end else begin
         countValid_r <= instValid;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stateCount_r <= TOTAL_RST;
         counts_r     <= {6{CNT_NONE}};
         unknown_r    <= 1'b0;
      end else if (instValid) begin
         stateCount_r <= sumNxt; // RULE9
         counts_r     <= counts;
         unknown_r    <= ~classOk;
      end
   end

   // running totals skip unknown classes so they never absorb a bogus zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         instTotal_r  <= ACC_RST;
         stateTotal_r <= ACC_RST;
      end else if (instValid && classOk) begin
         instTotal_r  <= instTotal_nxt;
         stateTotal_r <= stateTotal_nxt;
      end
   end

   assign countValid     = countValid_r;
   assign stateCount     = stateCount_r;
   assign fetchCycles    = counts_r[11:10];
   assign branchCycles   = counts_r[9:8];
   assign stackCycles    = counts_r[7:6];
   assign byteCycles     = counts_r[5:4];
   assign wordCycles     = counts_r[3:2];
   assign internalCycles = counts_r[1:0];
   assign instTotal      = instTotal_r;
   assign stateTotal     = stateTotal_r;
   assign unknownClass   = unknown_r;

endmodule

/* ist_pkg.sv */
// Purpose: shared constants and types for the instruction state timing model
// Assumes: one system clock, costs expressed in clock states
// Notes:   a target with no cost of its own for a cycle type reuses that target's own fetch cost
package ist_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int WAIT_W  = 4;
   localparam int COST_W  = 8;
   localparam int CNT_W   = 2;
   localparam int TOTAL_W = 16;
   localparam int ACC_W   = 32;

   ////////////////////////////////////////////////////////////////////////////////////////
   // access targets
   typedef enum logic [2:0] {
      TGT_ONCHIP_MEM = 3'h0,
      TGT_SUPMOD_8   = 3'h1,
      TGT_SUPMOD_16  = 3'h2,
      TGT_EXT8_2ST   = 3'h3,
      TGT_EXT8_3ST   = 3'h4,
      TGT_EXT16_2ST  = 3'h5,
      TGT_EXT16_3ST  = 3'h6
   } ist_target_e;

   ////////////////////////////////////////////////////////////////////////////////////////
   // instruction classes covered by the model
   typedef enum logic [4:0] {
      CLS_ADD_B_IMM   = 5'h00,
      CLS_ADD_B_REG   = 5'h01,
      CLS_ADD_W_IMM   = 5'h02,
      CLS_ADD_W_REG   = 5'h03,
      CLS_ADD_L_IMM   = 5'h04,
      CLS_ADD_L_REG   = 5'h05,
      CLS_ADD_PTR     = 5'h06,  // add_small_constant_to_pointer
      CLS_ADDX_IMM    = 5'h07,
      CLS_ADDX_REG    = 5'h08,
      CLS_AND_B_IMM   = 5'h09,
      CLS_AND_B_REG   = 5'h0a,
      CLS_AND_W_IMM   = 5'h0b,
      CLS_AND_W_REG   = 5'h0c,
      CLS_AND_L_IMM   = 5'h0d,
      CLS_AND_L_REG   = 5'h0e,
      CLS_AND_CCR     = 5'h0f,  // and_into_condition_codes
      CLS_BITAND_REG  = 5'h10,
      CLS_BITAND_IND  = 5'h11,
      CLS_BITAND_ABS  = 5'h12,
      CLS_BRANCH_D8   = 5'h13
   } ist_class_e;

   ////////////////////////////////////////////////////////////////////////////////////////
   // per-cycle state costs
   localparam logic [7:0] COST_FETCH_ONCHIP = 8'h02;
   localparam logic [7:0] COST_FETCH_SUP8   = 8'h06;
   localparam logic [7:0] COST_FETCH_SUP16  = 8'h03;
   localparam logic [7:0] COST_FETCH_EXT8_2 = 8'h04;
   localparam logic [7:0] COST_FETCH_EXT16_2 = 8'h02;
   localparam logic [7:0] COST_BYTE_SUP8    = 8'h03;
   localparam logic [7:0] COST_WORD_SUP8    = 8'h06;
   localparam logic [7:0] COST_BYTE_EXT8_2  = 8'h02;
   localparam logic [7:0] COST_WORD_EXT8_2  = 8'h04;
   localparam logic [7:0] COST_BASE_3ST_NARROW = 8'h03;
   localparam logic [7:0] COST_BASE_3ST_WIDE   = 8'h06;
   localparam logic [7:0] COST_INTERNAL     = 8'h01;

   ////////////////////////////////////////////////////////////////////////////////////////
   // cycle counts per instruction
   localparam logic [1:0] CNT_NONE  = 2'h0;
   localparam logic [1:0] CNT_ONE   = 2'h1;
   localparam logic [1:0] CNT_TWO   = 2'h2;
   localparam logic [1:0] CNT_THREE = 2'h3;

   // reset values
   localparam logic [15:0] TOTAL_RST = 16'h0000;
   localparam logic [31:0] ACC_RST   = 32'h0000_0000;

endpackage

/* ist_cycle_cost.sv */
// Purpose: state cost of one bus cycle of each type for the selected access target
// Assumes: wait count only matters for 3-state external targets
// Notes:   branch address read and stack cost as a word access on the same target
`timescale 1ns/10ps
module ist_cycle_cost
   import ist_pkg::*;
(
   input  wire ist_target_e          target,
   input  wire logic [WAIT_W-1:0]    waitStates,
   output logic [COST_W-1:0]         costFetch,
   output logic [COST_W-1:0]         costBranch,
   output logic [COST_W-1:0]         costStack,
   output logic [COST_W-1:0]         costByte,
   output logic [COST_W-1:0]         costWord,
   output logic [COST_W-1:0]         costInternal
);

   wire [COST_W-1:0] waitOne = COST_W'(waitStates);
   wire [COST_W-1:0] waitTwo = COST_W'({waitStates, 1'b0});
   wire [COST_W-1:0] narrow3 = COST_BASE_3ST_NARROW + waitOne;  // RULE2
   wire [COST_W-1:0] wide3   = COST_BASE_3ST_WIDE + waitTwo;    // RULE2

   always_comb begin
      costFetch = COST_FETCH_ONCHIP;
      costByte  = COST_FETCH_ONCHIP;
      costWord  = COST_FETCH_ONCHIP;
      case (target)
         TGT_SUPMOD_8: begin
            costFetch = COST_FETCH_SUP8;  // RULE1
            costByte  = COST_BYTE_SUP8;   // RULE3
            costWord  = COST_WORD_SUP8;   // RULE3
         end
         TGT_SUPMOD_16: begin
            costFetch = COST_FETCH_SUP16; // RULE1
            costByte  = COST_FETCH_SUP16;
            costWord  = COST_FETCH_SUP16;
         end
         TGT_EXT8_2ST: begin
            costFetch = COST_FETCH_EXT8_2; // RULE1
            costByte  = COST_BYTE_EXT8_2;  // RULE3
            costWord  = COST_WORD_EXT8_2;  // RULE3
         end
         TGT_EXT8_3ST: begin
            costFetch = wide3;   // RULE2
            costByte  = narrow3; // RULE2
            costWord  = wide3;   // RULE2
         end
         TGT_EXT16_2ST: begin
            costFetch = COST_FETCH_EXT16_2; // RULE1
            costByte  = COST_FETCH_EXT16_2;
            costWord  = COST_FETCH_EXT16_2;
         end
         TGT_EXT16_3ST: begin
            costFetch = narrow3; // RULE2
            costByte  = narrow3;
            costWord  = narrow3;
         end
         default: begin
            costFetch = COST_FETCH_ONCHIP; // RULE1
            costByte  = COST_FETCH_ONCHIP;
            costWord  = COST_FETCH_ONCHIP;
         end
      endcase
   end

   // vectors and stack entries are word-sized
   assign costBranch   = costWord;
   assign costStack    = costWord;
   assign costInternal = COST_INTERNAL; // RULE9

endmodule

/* ist_timing_chk.sv */
// Purpose: concurrent checks on the per-instruction state counter
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   bound into every ist_timing instance
`timescale 1ns/10ps
module ist_timing_chk import ist_pkg::*; (
   input wire logic               clk,
   input wire logic               rst,
   input wire logic               instValid,
   input wire ist_class_e         instClass,
   input wire ist_target_e        target,
   input wire logic [WAIT_W-1:0]  waitStates,
   input wire logic               countValid,
   input wire logic [TOTAL_W-1:0] stateCount,
   input wire logic [CNT_W-1:0]   fetchCycles,
   input wire logic [CNT_W-1:0]   byteCycles,
   input wire logic [CNT_W-1:0]   wordCycles,
   input wire logic [ACC_W-1:0]   stateTotal,
   input wire logic               unknownClass
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire logic known = instValid && (instClass <= CLS_BRANCH_D8);
   ////////////////////////////////////////////////////////////////////////////////////////
   a_answer_next: assert property (instValid |=> countValid)
      else $error("no countValid after request");
   a_idle_hold: assert property (!instValid |=> !countValid && $stable(stateCount))
      else $error("outputs moved without request");
   a_long_add: assert property (instValid && instClass == CLS_ADD_L_IMM |=>
      fetchCycles == CNT_THREE && byteCycles == CNT_NONE) else $error("long add counts wrong");
   a_branch_two: assert property (instValid && instClass == CLS_BRANCH_D8 |=>
      fetchCycles == CNT_TWO && byteCycles == CNT_NONE && wordCycles == CNT_NONE)
      else $error("short branch counts wrong");
   a_bitand_mem: assert property (instValid && instClass inside {CLS_BITAND_IND,
      CLS_BITAND_ABS} |=> fetchCycles == CNT_TWO && byteCycles == CNT_ONE)
      else $error("bit-and memory counts wrong");
   a_onchip_sum: assert property (known && target == TGT_ONCHIP_MEM |=>
      stateCount == 16'(fetchCycles) * 16'h2 + 16'(byteCycles) * 16'h2)
      else $error("on-chip state sum wrong");
   a_ext16_wait: assert property (instValid && instClass == CLS_BRANCH_D8 &&
      target == TGT_EXT16_3ST |=> stateCount == 16'(2 * (3 + $past(waitStates))))
      else $error("3-state wait cost wrong");
   a_sup8_fetch: assert property (instValid && instClass == CLS_ADD_B_REG &&
      target == TGT_SUPMOD_8 |=> stateCount == 16'h0006) else $error("module fetch cost wrong");
   a_total_sum: assert property (known |=>
      stateTotal == $past(stateTotal) + 32'(stateCount)) else $error("running total wrong");
   a_unknown_zero: assert property (instValid && instClass > CLS_BRANCH_D8 |=>
      unknownClass && stateCount == 16'h0 && $stable(stateTotal))
      else $error("unknown class not flagged");
endmodule
bind ist_timing ist_timing_chk chk (.clk(clk), .rst(rst), .instValid(instValid),
   .instClass(instClass), .target(target), .waitStates(waitStates), .countValid(countValid),
   .stateCount(stateCount), .fetchCycles(fetchCycles), .byteCycles(byteCycles),
   .wordCycles(wordCycles), .stateTotal(stateTotal), .unknownClass(unknownClass));

/* ist_ext_dev_model.sv */
// Purpose: external bus device that reports its inserted wait states
// Assumes: only 3-state targets insert waits
// Notes:   unselected device shows a moving pattern, never a stale figure
`timescale 1ns/10ps
module ist_ext_dev_model import ist_pkg::*; (
   input  wire logic        clk,
   input  wire ist_target_e target,
   input  wire logic [3:0]  cfgWait,
   output logic [3:0]       waitStates
);
   logic [3:0] junk_r = 4'h9;
   always_ff @(posedge clk) junk_r <= junk_r + 4'h7;
   assign waitStates = (target inside {TGT_EXT8_3ST, TGT_EXT16_3ST}) ? cfgWait : junk_r;
endmodule

/* tb_top.sv */
// Purpose: swept and random checking of per-instruction state counts
// Assumes: requests change at the rising edge; results are read at the falling edge
// Notes:   expected counts come from per-class cycle counts and per-target state costs
`timescale 1ns/10ps
module tb_top import ist_pkg::*;;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        instValid = 1'b0;
   ist_class_e  instClass = CLS_ADD_B_IMM;
   ist_target_e target = TGT_ONCHIP_MEM;
   logic [3:0]  cfgWait = 4'h0;
   logic        branchTaken = 1'b0;
   wire  [3:0]  waitStates;
   logic        countValid, unknownClass, eV;
   logic [15:0] stateCount;
   logic [1:0]  fetchCycles, branchCycles, stackCycles, byteCycles, wordCycles, internalCycles;
   logic [31:0] instTotal, stateTotal, expTot, expCnt;
   ist_class_e  eC;
   ist_target_e eT;
   logic [3:0]  eW;
   int          error_cnt = 0;
   int          compares = 0;
   int          cyc = 0;
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////////////
   ist_ext_dev_model dev (.clk(clk), .target(target), .cfgWait(cfgWait), .waitStates(waitStates));
   ist_timing dut (.clk(clk), .rst(rst), .instValid(instValid), .instClass(instClass),
      .target(target), .waitStates(waitStates), .branchTaken(branchTaken),
      .countValid(countValid), .stateCount(stateCount), .fetchCycles(fetchCycles),
      .branchCycles(branchCycles), .stackCycles(stackCycles), .byteCycles(byteCycles),
      .wordCycles(wordCycles), .internalCycles(internalCycles), .instTotal(instTotal),
      .stateTotal(stateTotal), .unknownClass(unknownClass));
   ////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [1:0] fetchN(ist_class_e c);
      case (c)
         CLS_ADD_L_IMM, CLS_AND_L_IMM: return 2'h3;
         CLS_ADD_W_IMM, CLS_AND_W_IMM, CLS_AND_L_REG, CLS_BITAND_IND, CLS_BITAND_ABS,
         CLS_BRANCH_D8: return 2'h2;
         default: return (c > CLS_BRANCH_D8) ? 2'h0 : 2'h1;
      endcase
   endfunction
   function automatic logic [1:0] byteN(ist_class_e c);
      return (c inside {CLS_BITAND_IND, CLS_BITAND_ABS}) ? 2'h1 : 2'h0;
   endfunction
   // per-target base cost and wait multiplier for fetch and byte cycles
   function automatic logic [15:0] states(ist_class_e c, ist_target_e t, logic [3:0] w);
      int si[7] = '{2, 6, 3, 4, 6, 2, 3};
      int mi[7] = '{0, 0, 0, 0, 2, 0, 1};
      int sl[7] = '{2, 3, 3, 2, 3, 2, 3};
      int ml[7] = '{0, 0, 0, 0, 1, 0, 1};
      return 16'(fetchN(c) * (si[t] + mi[t] * w) + byteN(c) * (sl[t] + ml[t] * w));
   endfunction
   task automatic chk(logic ok, string m);
      compares++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic end_of_test();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic drive(logic v, int c, int t, logic [3:0] w);
      @(posedge clk);
      instValid <= v;
      instClass <= ist_class_e'(c);
      target <= ist_target_e'(t);
      cfgWait <= w;
      branchTaken <= 1'($urandom_range(1));
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////
   // capture what the design sampled, before this edge's stimulus lands
   always @(posedge clk) begin
      eV <= instValid & ~rst;
      eC <= instClass;
      eT <= target;
      eW <= waitStates;
      cyc++;
      if (cyc > 10000) begin
         error_cnt++;
         $display("[FAIL] %0t timeout", $time);
         end_of_test();
      end
   end
   always @(negedge clk) begin
      if (rst) begin
         expTot = 32'h0;
         expCnt = 32'h0;
         chk(stateTotal === 32'h0 && countValid === 1'b0, "reset state");
      end else begin
         chk(countValid === eV, "countValid");
         if (eV) begin
            chk(stateCount === states(eC, eT, eW), "stateCount");
            chk(fetchCycles === fetchN(eC), "fetch cycles");
            chk(byteCycles === byteN(eC), "byte cycles");
            chk({branchCycles, stackCycles, wordCycles, internalCycles} === 8'h0, "others");
            chk(unknownClass === (eC > CLS_BRANCH_D8), "unknown flag");
            if (eC <= CLS_BRANCH_D8) begin
               expTot += 32'(states(eC, eT, eW));
               expCnt += 32'h1;
            end
         end
         chk(stateTotal === expTot && instTotal === expCnt, "totals");
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h9f5c));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      // back to back over every class, two codes past the last, and every target
      for (int c = 0; c < 22; c++)
         for (int t = 0; t < 7; t++)
            drive(1'b1, c, t, (c % 2) ? 4'hf : 4'h0);
      drive(1'b0, 0, 0, 4'h0);
      $display("test sweep done");
      for (int i = 0; i < 3000; i++)
         drive($urandom_range(3) != 0, $urandom_range(21), $urandom_range(6),
               4'($urandom_range(15)));
      drive(1'b0, 0, 0, 4'h0);
      $display("test random done");
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      drive(1'b1, 4, 1, 4'h0);
      drive(1'b1, 18, 6, 4'h1);
      drive(1'b0, 0, 0, 4'h0);
      repeat (2) @(posedge clk);
      $display("test reset done");
      end_of_test();
   end
endmodule
